// ### rtl/uctl_core.sv
// uctl_core: interrupt, fifo status, dma, sleep and break control
// assumes: external shifters push received characters and take
// transmit characters; plain register port on the same clock
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - seven interrupt sources arbitrated, highest priority reported
// - ident low six bits read 000001 when nothing pending
// - line errors report 000110; overrun cleared by line status read
// - stale receive data reports 001100, cleared by holding read
// - receive data or trigger fill reports 000100, cleared by read
// - transmit empty or trigger reports 000010, cleared by ident/write
// - flow character 010000; off cleared by on, special by ident read
// - handshake low to high reports 100000, cleared by ident read
// - error summary set while any stored character has an error
// - line status 4:2 show head character flags, zero when empty
// - interrupt output from enabled sources; all clear means polling
// - dma mode from fifo control bit 3, single when fifo off
// - single mode: tx request when empty, rx while data held
// - block mode tx request on free trigger space, drop on full
// - block rx request on trigger or timeout, drop on empty/error
// - sleep only when enabled, idle, tx empty, no real interrupts
// - sleep stops clocks; wake on rx, modem pin, or tx write
// - receive idle after four character times of mid-bit highs
// - line control bit 6 forces serial output low
// - optional divide-by-four prescaler then 16-bit divisor
// - divisor from two bytes; zero divisor gives no baud clock
module uctl_core #(
	parameter int DEPTH = 64,
	parameter int CHAR_BITS = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	// receiver side
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char_data,
	input wire logic [2:0] rx_char_flags,
	input wire logic xoff_detect,
	input wire logic xon_detect,
	input wire logic special_detect,
	// transmitter side
	input wire logic tx_take,
	input wire logic tx_shift_empty,
	input wire logic tx_line,
	output logic [7:0] tx_data,
	output logic tx_valid,
	// pins
	input wire logic serial_in,
	input wire logic clear_send_in_n,
	output logic serial_out,
	output logic request_send_out_n,
	output logic tx_dma_request_n,
	output logic rx_dma_request_n,
	output logic irq,
	// status
	output logic baud_tick16,
	output logic sleep_active,
	output logic rx_line
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	typedef logic [CW-1:0] uctl_cnt_t;

	logic [7:0] ier_q, lcr_q, mcr_q, fcr_q, efr_q, dll_q, dlm_q;
	logic [1:0] sync1_q, sync2_q, sync3_q, pin_q;
	logic [10:0] rx_mem [DEPTH];
	logic [7:0] tx_mem [DEPTH];
	logic [AW-1:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q;
	uctl_cnt_t rx_cnt_q, tx_cnt_q, err_cnt_q, rx_cap, rx_trig, tx_trig;
	logic overrun_q, timeout_q, thr_q, thr_cond_q, xoff_q, special_q;
	logic hsk_q, dcts_q, rts_prev_q, sleep_q, txdma_q, rxdma_q;
	logic rx_push, rx_pop, rx_full, tx_push, tx_pop, tx_full;
	logic rd_hold, rd_ident, rd_lsr, rd_msr, wr_fcr, thr_cond;
	logic line_int, rxd_int, modem_int, xoff_int, idle, idle_rise;
	logic fifo_on, block_mode, rxfifo_rst, txfifo_rst, wake;
	logic [2:0] head_flags;
	logic [5:0] ident;
	logic [7:0] line_status_reg, modem_status_reg;
	logic cts_prev_q, cts_change, wake_cts_rise;

	// ----------------------------------------
	// register port decode
	// ----------------------------------------
	assign rd_hold = rd_stb && addr == uctl_pkg::ADDR_HOLD;
	assign rd_ident = rd_stb && addr == uctl_pkg::ADDR_IDENT;
	assign rd_lsr = rd_stb && addr == uctl_pkg::ADDR_LSR;
	assign rd_msr = rd_stb && addr == uctl_pkg::ADDR_MSR;
	assign wr_fcr = wr_stb && addr == uctl_pkg::ADDR_IDENT;
	assign rxfifo_rst = wr_fcr && wdata[uctl_pkg::FCR_RXRST];
	assign txfifo_rst = wr_fcr && wdata[uctl_pkg::FCR_TXRST];
	assign fifo_on = fcr_q[uctl_pkg::FCR_EN];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ier_q <= uctl_pkg::ZERO_RST;
			lcr_q <= uctl_pkg::LCR_RST;
			mcr_q <= uctl_pkg::ZERO_RST;
			fcr_q <= uctl_pkg::ZERO_RST;
			efr_q <= uctl_pkg::ZERO_RST;
			dll_q <= uctl_pkg::ZERO_RST;
			dlm_q <= uctl_pkg::ZERO_RST;
		end else if (wr_stb) begin
			case (addr)
				uctl_pkg::ADDR_IER: ier_q <= wdata;
				uctl_pkg::ADDR_IDENT: fcr_q <= wdata & 8'hF9;
				uctl_pkg::ADDR_LCR: lcr_q <= wdata;
				uctl_pkg::ADDR_MCR: mcr_q <= wdata;
				uctl_pkg::ADDR_EFR: efr_q <= wdata;
				uctl_pkg::ADDR_DIVLO: dll_q <= wdata;
				uctl_pkg::ADDR_DIVHI: dlm_q <= wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= 8'h00;
			if (rd_stb) begin
				case (addr)
					uctl_pkg::ADDR_HOLD: rdata <= rx_mem[rx_rd_q][7:0];
					uctl_pkg::ADDR_IER: rdata <= ier_q;
					uctl_pkg::ADDR_IDENT: rdata <= {2'h0, ident};
					uctl_pkg::ADDR_LCR: rdata <= lcr_q;
					uctl_pkg::ADDR_MCR: rdata <= mcr_q;
					uctl_pkg::ADDR_LSR: rdata <= line_status_reg;
					uctl_pkg::ADDR_MSR: rdata <= modem_status_reg;
					uctl_pkg::ADDR_DIVLO: rdata <= dll_q;
					uctl_pkg::ADDR_DIVHI: rdata <= dlm_q;
					uctl_pkg::ADDR_EFR: rdata <= efr_q;
					default: rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 2'h3;
			sync2_q <= 2'h3;
			sync3_q <= 2'h3;
			pin_q <= 2'h3;
		end else begin
			sync1_q <= {clear_send_in_n, serial_in};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < 2; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					pin_q[i] <= sync3_q[i];
				end
			end
		end
	end
	assign rx_line = pin_q[0];

	// ----------------------------------------
	// receive fifo
	// ----------------------------------------
	assign rx_cap = fifo_on ? uctl_cnt_t'(DEPTH) : uctl_cnt_t'(1);
	assign rx_full = rx_cnt_q >= rx_cap;
	assign rx_push = rx_char_valid && !rx_full;
	assign rx_pop = rd_hold && rx_cnt_q != '0;

	always_ff @(posedge clk) begin
		if (rx_push) begin
			rx_mem[rx_wr_q] <= {rx_char_flags, rx_char_data};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_wr_q <= '0;
			rx_rd_q <= '0;
			rx_cnt_q <= '0;
			err_cnt_q <= '0;
		end else if (rxfifo_rst) begin
			rx_wr_q <= '0;
			rx_rd_q <= '0;
			rx_cnt_q <= '0;
			err_cnt_q <= '0;
		end else begin
			rx_wr_q <= rx_push ? rx_wr_q + 1'b1 : rx_wr_q;
			rx_rd_q <= rx_pop ? rx_rd_q + 1'b1 : rx_rd_q;
			rx_cnt_q <= rx_cnt_q + uctl_cnt_t'(rx_push) -
				uctl_cnt_t'(rx_pop);
			err_cnt_q <= err_cnt_q +
				uctl_cnt_t'(rx_push && rx_char_flags != 3'h0) -
				uctl_cnt_t'(rx_pop && rx_mem[rx_rd_q][10:8] != 3'h0);
		end
	end

	assign head_flags = (rx_cnt_q != '0) ? rx_mem[rx_rd_q][10:8] : 3'h0;

	// ----------------------------------------
	// transmit fifo
	// ----------------------------------------
	assign tx_full = tx_cnt_q >= rx_cap;
	assign tx_push = wr_stb && addr == uctl_pkg::ADDR_HOLD && !tx_full;
	assign tx_pop = tx_take && tx_cnt_q != '0;
	assign tx_valid = tx_cnt_q != '0;
	assign tx_data = tx_mem[tx_rd_q];

	always_ff @(posedge clk) begin
		if (tx_push) begin
			tx_mem[tx_wr_q] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_wr_q <= '0;
			tx_rd_q <= '0;
			tx_cnt_q <= '0;
		end else if (txfifo_rst) begin
			tx_wr_q <= '0;
			tx_rd_q <= '0;
			tx_cnt_q <= '0;
		end else begin
			tx_wr_q <= tx_push ? tx_wr_q + 1'b1 : tx_wr_q;
			tx_rd_q <= tx_pop ? tx_rd_q + 1'b1 : tx_rd_q;
			tx_cnt_q <= tx_cnt_q + uctl_cnt_t'(tx_push) -
				uctl_cnt_t'(tx_pop);
		end
	end

	// ----------------------------------------
	// trigger levels and status words
	// ----------------------------------------
	always_comb begin
		case (fcr_q[7:6])
			2'h0: rx_trig = uctl_cnt_t'(8);
			2'h1: rx_trig = uctl_cnt_t'(16);
			2'h2: rx_trig = uctl_cnt_t'(56);
			default: rx_trig = uctl_cnt_t'(60);
		endcase
		case (fcr_q[5:4])
			2'h0: tx_trig = uctl_cnt_t'(8);
			2'h1: tx_trig = uctl_cnt_t'(16);
			2'h2: tx_trig = uctl_cnt_t'(32);
			default: tx_trig = uctl_cnt_t'(56);
		endcase
	end

	assign line_status_reg = {err_cnt_q != '0, tx_cnt_q == '0 && tx_shift_empty,
		tx_cnt_q == '0, head_flags, overrun_q, rx_cnt_q != '0};
	assign modem_status_reg = {3'h0, ~pin_q[1], 3'h0, dcts_q};

	// ----------------------------------------
	// interrupt sources
	// ----------------------------------------
	assign thr_cond = fifo_on ? (rx_cap - tx_cnt_q >= tx_trig) :
		(tx_cnt_q == '0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overrun_q <= 1'b0;
		end else if (rx_char_valid && rx_full) begin
			overrun_q <= 1'b1;
		end else if (rd_lsr) begin
			overrun_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timeout_q <= 1'b0;
		end else if (idle_rise && rx_cnt_q != '0) begin
			timeout_q <= 1'b1;
		end else if (rd_hold || rx_cnt_q == '0) begin
			timeout_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			thr_cond_q <= 1'b0;
			thr_q <= 1'b0;
		end else begin
			thr_cond_q <= thr_cond;
			if (thr_cond && !thr_cond_q) begin
				thr_q <= 1'b1;
			end else if ((rd_ident && ident == uctl_pkg::ID_THR) ||
				tx_push || !thr_cond) begin
				thr_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xoff_q <= 1'b0;
			special_q <= 1'b0;
		end else begin
			if (xoff_detect) begin
				xoff_q <= 1'b1;
			end else if (xon_detect) begin
				xoff_q <= 1'b0;
			end
			if (special_detect && efr_q[uctl_pkg::EFR_SPECIAL]) begin
				special_q <= 1'b1;
			end else if (rd_ident && ident == uctl_pkg::ID_XOFF) begin
				special_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hsk_q <= 1'b0;
			dcts_q <= 1'b0;
			rts_prev_q <= 1'b1;
		end else begin
			rts_prev_q <= request_send_out_n;
			if ((ier_q[uctl_pkg::IER_CTS] && wake_cts_rise) ||
				(ier_q[uctl_pkg::IER_RTS] &&
				request_send_out_n && !rts_prev_q)) begin
				hsk_q <= 1'b1;
			end else if (rd_ident && ident == uctl_pkg::ID_HSK) begin
				hsk_q <= 1'b0;
			end
			if (cts_change) begin
				dcts_q <= 1'b1;
			end else if (rd_msr) begin
				dcts_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cts_prev_q <= 1'b1;
		end else begin
			cts_prev_q <= pin_q[1];
		end
	end
	assign cts_change = pin_q[1] != cts_prev_q;
	assign wake_cts_rise = pin_q[1] && !cts_prev_q;

	assign line_int = ier_q[uctl_pkg::IER_LINE] &&
		(err_cnt_q != '0 || overrun_q);
	assign rxd_int = ier_q[uctl_pkg::IER_RXDATA] &&
		(fifo_on ? rx_cnt_q >= rx_trig : rx_cnt_q != '0);
	assign modem_int = ier_q[uctl_pkg::IER_MODEM] && dcts_q;
	assign xoff_int = ier_q[uctl_pkg::IER_XOFF] && (xoff_q || special_q);

	always_comb begin
		ident = uctl_pkg::ID_NONE;
		if (line_int) begin
			ident = uctl_pkg::ID_LINE;
		end else if (ier_q[uctl_pkg::IER_RXDATA] && timeout_q) begin
			ident = uctl_pkg::ID_TMO;
		end else if (rxd_int) begin
			ident = uctl_pkg::ID_RXDATA;
		end else if (ier_q[uctl_pkg::IER_THR] && thr_q) begin
			ident = uctl_pkg::ID_THR;
		end else if (modem_int) begin
			ident = uctl_pkg::ID_MODEM;
		end else if (xoff_int) begin
			ident = uctl_pkg::ID_XOFF;
		end else if (hsk_q) begin
			ident = uctl_pkg::ID_HSK;
		end
	end

	assign irq = ident != uctl_pkg::ID_NONE;

	// ----------------------------------------
	// dma requests
	// ----------------------------------------
	// mode select
	assign block_mode = fcr_q[uctl_pkg::FCR_DMA] && fifo_on;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txdma_q <= 1'b1;
			rxdma_q <= 1'b0;
		end else if (!block_mode) begin
			txdma_q <= tx_cnt_q == '0;
			rxdma_q <= rx_cnt_q != '0;
		end else begin
			if (tx_full) begin
				txdma_q <= 1'b0;
			end else if (rx_cap - tx_cnt_q >= tx_trig) begin
				txdma_q <= 1'b1;
			end
			if (rx_cnt_q == '0 || err_cnt_q != '0) begin
				rxdma_q <= 1'b0;
			end else if (rx_cnt_q >= rx_trig || timeout_q) begin
				rxdma_q <= 1'b1;
			end
		end
	end
	assign tx_dma_request_n = !txdma_q;
	assign rx_dma_request_n = !rxdma_q;

	// ----------------------------------------
	// sleep, break, baud
	// ----------------------------------------
	// wake events
	assign wake = (sync3_q[0] != pin_q[0]) || cts_change || tx_push;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_q <= 1'b0;
		end else if (wake || !(efr_q[uctl_pkg::EFR_ENH] &&
			ier_q[uctl_pkg::IER_SLEEP])) begin
			sleep_q <= 1'b0;
		end else if (idle && tx_cnt_q == '0 && tx_shift_empty &&
			rx_cnt_q == '0 && pin_q[0] && !line_int && !rxd_int &&
			!modem_int && !xoff_int && !hsk_q) begin
			sleep_q <= 1'b1;
		end
	end
	assign sleep_active = sleep_q;

	assign serial_out = tx_line && !lcr_q[uctl_pkg::LCR_BREAK];
	assign request_send_out_n = !mcr_q[uctl_pkg::MCR_RTS];

	uctl_baud u_baud (
		.clk(clk),
		.rst(rst),
		.run(!sleep_q),
		.presc_sel(mcr_q[uctl_pkg::MCR_PRESC]),
		.divisor({dlm_q, dll_q}),
		.tick16(baud_tick16)
	);

	uctl_idle #(.CHAR_BITS(CHAR_BITS)) u_idle (
		.clk(clk),
		.rst(rst),
		.tick16(baud_tick16),
		.rx_line(pin_q[0]),
		.restart(rx_char_valid),
		.idle(idle),
		.idle_rise(idle_rise)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_none;
		!(line_int || rxd_int || modem_int || xoff_int || hsk_q ||
		timeout_q || thr_q) |-> ident == 6'h01 && !irq;
	endproperty
	a_none: assert property (p_none) else $error("ident not none");
	property p_line;
		line_int |-> ident == 6'h06;
	endproperty
	a_line: assert property (p_line) else $error("line not top");
	property p_ovr;
		rd_lsr && !(rx_char_valid && rx_full) |=> !overrun_q;
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun kept");
	property p_head;
		rx_cnt_q == '0 |-> line_status_reg[4:2] == 3'h0;
	endproperty
	a_head: assert property (p_head) else $error("flags not zero");
	property p_brk;
		lcr_q[6] |-> !serial_out;
	endproperty
	a_brk: assert property (p_brk) else $error("break not low");
	property p_single;
		!block_mode && $stable(block_mode) ##0 tx_cnt_q != '0
		|=> tx_dma_request_n;
	endproperty
	a_single: assert property (p_single) else $error("tx dma held");
	property p_sleep;
		rx_cnt_q != '0 |=> !sleep_q;
	endproperty
	a_sleep: assert property (p_sleep) else $error("slept with data");
	property p_hsk;
		rd_ident && ident == 6'h20 && !wake_cts_rise &&
		!(request_send_out_n && !rts_prev_q) |=> !hsk_q;
	endproperty
	a_hsk: assert property (p_hsk) else $error("handshake kept");
endmodule
`default_nettype wire

// ### rtl/uctl_pkg.sv
// uctl_pkg: constants for the per-channel serial control block
// assumes: shared by the core, baud generator and idle detector
package uctl_pkg;
	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [3:0] ADDR_HOLD = 4'h0;
	localparam logic [3:0] ADDR_IER = 4'h1;
	localparam logic [3:0] ADDR_IDENT = 4'h2;
	localparam logic [3:0] ADDR_LCR = 4'h3;
	localparam logic [3:0] ADDR_MCR = 4'h4;
	localparam logic [3:0] ADDR_LSR = 4'h5;
	localparam logic [3:0] ADDR_MSR = 4'h6;
	localparam logic [3:0] ADDR_DIVLO = 4'h8;
	localparam logic [3:0] ADDR_DIVHI = 4'h9;
	localparam logic [3:0] ADDR_EFR = 4'hA;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int IER_RXDATA = 0;
	localparam int IER_THR = 1;
	localparam int IER_LINE = 2;
	localparam int IER_MODEM = 3;
	localparam int IER_SLEEP = 4;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int FCR_DMA = 3;
	localparam int LCR_BREAK = 6;
	localparam int MCR_RTS = 1;
	localparam int MCR_PRESC = 7;
	localparam int EFR_ENH = 4;
	localparam int EFR_SPECIAL = 5;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] LCR_RST = 8'h1D;
	localparam logic [7:0] ZERO_RST = 8'h00;
	// ----------------------------------------
	// identification codes
	// ----------------------------------------
	localparam logic [5:0] ID_NONE = 6'h01;
	localparam logic [5:0] ID_LINE = 6'h06;
	localparam logic [5:0] ID_TMO = 6'h0C;
	localparam logic [5:0] ID_RXDATA = 6'h04;
	localparam logic [5:0] ID_THR = 6'h02;
	localparam logic [5:0] ID_MODEM = 6'h00;
	localparam logic [5:0] ID_XOFF = 6'h10;
	localparam logic [5:0] ID_HSK = 6'h20;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int PRESC_DIV = 4;
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] MID_BIT = 4'h7;
	localparam int IDLE_CHARS = 4;
endpackage

// ### rtl/uctl_baud.sv
// uctl_baud: prescaler and 16-bit divisor, one tick per 16x period
// assumes: divisor bytes held steady while the channel is running
`timescale 1ns/1ps
`default_nettype none
module uctl_baud (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic presc_sel,
	input wire logic [15:0] divisor,
	// output
	output logic tick16
);
	logic [1:0] pre_q;
	logic [15:0] div_q;
	logic pre_tick;

	assign pre_tick = presc_sel ?
		(pre_q == 2'(uctl_pkg::PRESC_DIV - 1)) : 1'b1;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q <= 2'h0;
		end else if (run) begin
			pre_q <= pre_tick ? 2'h0 : pre_q + 2'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= 16'h0000;
			tick16 <= 1'b0;
		end else begin
			tick16 <= 1'b0;
			if (run && divisor != 16'h0000 && pre_tick) begin
				if (div_q >= divisor - 16'h0001) begin
					div_q <= 16'h0000;
					tick16 <= 1'b1;
				end else begin
					div_q <= div_q + 16'h0001;
				end
			end
		end
	end

	property p_no_div;
		@(posedge clk) disable iff (rst)
		(divisor == 16'h0000) [*2] |-> !tick16;
	endproperty
	a_no_div: assert property (p_no_div) else $error("tick at zero divisor");
endmodule
`default_nettype wire

// ### rtl/uctl_idle.sv
// uctl_idle: receive line idle detection by mid-bit sampling
// assumes: rx_line already synchronised, tick16 from the baud generator
`timescale 1ns/1ps
`default_nettype none
module uctl_idle #(
	parameter int CHAR_BITS = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// inputs
	input wire logic tick16,
	input wire logic rx_line,
	input wire logic restart,
	// outputs
	output logic idle,
	output logic idle_rise
);
	localparam int LIMIT = uctl_pkg::IDLE_CHARS * CHAR_BITS;
	logic [3:0] phase_q;
	logic [7:0] high_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q <= 4'h0;
		end else if (tick16) begin
			phase_q <= phase_q + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			high_q <= 8'h00;
		end else if (restart || (tick16 && !rx_line)) begin
			high_q <= 8'h00;
		end else if (tick16 && phase_q == uctl_pkg::MID_BIT &&
			high_q < 8'(LIMIT)) begin
			high_q <= high_q + 8'h01;
		end
	end

	assign idle = (high_q == 8'(LIMIT));
	assign idle_rise = tick16 && phase_q == uctl_pkg::MID_BIT &&
		rx_line && !restart && high_q == 8'(LIMIT - 1);

	property p_idle;
		@(posedge clk) disable iff (rst)
		idle_rise |=> idle;
	endproperty
	a_idle: assert property (p_idle) else $error("idle not reached");
endmodule
`default_nettype wire

// ### tb/uctl_tx_far.sv
// uctl_tx_far: transmit shifter model on the far side of the core
// assumes: core offers tx_valid; hold_off stalls the shifter
`timescale 1ns/1ps
`default_nettype none
module uctl_tx_far #(
	parameter int HOLD = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fifo side
	input wire logic tx_valid,
	input wire logic hold_off,
	output logic tx_take,
	// line side
	output logic tx_shift_empty,
	output logic tx_line
);
	logic [7:0] cnt_q;
	// ----------------------------------------
	// one character per HOLD+1 cycles
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
			tx_take <= 1'b0;
		end else begin
			tx_take <= 1'b0;
			if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q - 8'h01;
			end else if (tx_valid && !tx_take && !hold_off) begin
				tx_take <= 1'b1;
				cnt_q <= 8'(HOLD);
			end
		end
	end
	// idle line high, busy line toggles
	assign tx_shift_empty = (cnt_q == 8'h00);
	assign tx_line = tx_shift_empty | cnt_q[0];
endmodule
`default_nettype wire

// ### tb/tb.sv
// tb: register-port bench for the serial control core
// assumes: shifter model on the far side, 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst, wr_stb, rd_stb, rx_char_valid, serial_in, cts_n, hold_off;
	logic tx_take, tx_shift_empty, tx_line, tx_valid, serial_out, rts_n;
	logic txr_n, rxr_n, irq, tick, sleep;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, rx_char_data;
	logic [2:0] rx_char_flags, det;
	int errors, checks_done, cycles, ticks;
	uctl_core uctl_core_inst (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_char_flags(rx_char_flags), .xoff_detect(det[0]),
		.xon_detect(det[1]), .special_detect(det[2]), .tx_take(tx_take),
		.tx_shift_empty(tx_shift_empty), .tx_line(tx_line), .tx_data(),
		.tx_valid(tx_valid), .serial_in(serial_in),
		.clear_send_in_n(cts_n), .serial_out(serial_out),
		.request_send_out_n(rts_n), .tx_dma_request_n(txr_n),
		.rx_dma_request_n(rxr_n), .irq(irq), .baud_tick16(tick),
		.sleep_active(sleep), .rx_line());
	uctl_tx_far uctl_tx_far_inst (.clk(clk), .rst(rst), .tx_valid(tx_valid),
		.hold_off(hold_off), .tx_take(tx_take),
		.tx_shift_empty(tx_shift_empty), .tx_line(tx_line));
	// ----------------------------------------
	// clock, tick count, timeout
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (tick === 1'b1) ticks++;
		if (cycles == 30000) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			wrap_up;
		end
	end
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1;
		@(posedge clk);
		wr_stb <= 0;
	endtask
	task cmp(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1;
		@(posedge clk);
		rd_stb <= 0;
		#1;
		cmp(rdata, e);
	endtask
	task id(input logic [7:0] e);
		chk(4'h2, e);
	endtask
	task push(input logic [2:0] f);
		@(posedge clk);
		rx_char_valid <= 1;
		rx_char_flags <= f;
		@(posedge clk);
		rx_char_valid <= 0;
		cyc(1);
	endtask
	task pulse(input int i);
		@(posedge clk);
		det[i] <= 1;
		@(posedge clk);
		det <= 3'h0;
	endtask
	task gap(input logic [7:0] e);
		logic [7:0] n;
		n = 8'h01;
		cyc(1);
		while (tick !== 1'b1) cyc(1);
		cyc(1);
		while (tick !== 1'b1) begin
			n++;
			cyc(1);
		end
		cmp(n, e);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1; addr = 0; wdata = 0; wr_stb = 0; rd_stb = 0; det = 0;
		rx_char_valid = 0; rx_char_data = 8'h5A; rx_char_flags = 0;
		serial_in = 1; cts_n = 1; hold_off = 0;
		cyc(16);
		rst <= 0;
		cyc(40);
		id(8'h01);
		cmp({6'h00, txr_n, rxr_n}, 8'h01);
		cmp(8'(ticks), 8'h00);
		wr(4'h1, 8'h01);
		push(3'h0);
		cmp({7'h00, irq}, 8'h01);
		cmp({7'h00, rxr_n}, 8'h00);
		id(8'h04);
		chk(4'h0, 8'h5A);
		id(8'h01);
		wr(4'h1, 8'h00);
		push(3'h0);
		cmp({7'h00, irq}, 8'h00);
		push(3'h0);
		chk(4'h5, 8'h63);
		chk(4'h5, 8'h61);
		chk(4'h0, 8'h5A);
		wr(4'h1, 8'h05);
		push(3'h2);
		id(8'h06);
		chk(4'h5, 8'hE9);
		chk(4'h0, 8'h5A);
		chk(4'h5, 8'h60);
		id(8'h01);
		wr(4'h3, 8'h43);
		cyc(1);
		cmp({7'h00, serial_out}, 8'h00);
		wr(4'h3, 8'h03);
		cyc(1);
		cmp({7'h00, serial_out}, 8'h01);
		hold_off <= 1;
		wr(4'h1, 8'h02);
		wr(4'h0, 8'hC3);
		cyc(3);
		cmp({7'h00, txr_n}, 8'h01);
		hold_off <= 0;
		cyc(20);
		cmp({7'h00, txr_n}, 8'h00);
		id(8'h02);
		id(8'h01);
		wr(4'h1, 8'h20);
		pulse(0);
		id(8'h10);
		pulse(1);
		id(8'h01);
		wr(4'hA, 8'h20);
		pulse(2);
		id(8'h10);
		id(8'h01);
		wr(4'h1, 8'h80);
		@(posedge clk) cts_n <= 0;
		cyc(8);
		@(posedge clk) cts_n <= 1;
		cyc(8);
		id(8'h20);
		id(8'h01);
		wr(4'h1, 8'h08);
		id(8'h00);
		chk(4'h6, 8'h01);
		id(8'h01);
		wr(4'h8, 8'h04);
		wr(4'h9, 8'h00);
		gap(8'h04);
		wr(4'h4, 8'h80);
		gap(8'h10);
		wr(4'h4, 8'h00);
		wr(4'h8, 8'h01);
		wr(4'h2, 8'h09);
		wr(4'h1, 8'h01);
		push(3'h0);
		cmp({6'h00, txr_n, rxr_n}, 8'h01);
		for (int i = 0; i < 3000 && irq !== 1'b1; i++) cyc(1);
		cyc(1);
		cmp({7'h00, rxr_n}, 8'h00);
		id(8'h0C);
		chk(4'h0, 8'h5A);
		id(8'h01);
		cmp({7'h00, rxr_n}, 8'h01);
		wr(4'hA, 8'h10);
		wr(4'h1, 8'h10);
		for (int i = 0; i < 3000 && sleep !== 1'b1; i++) cyc(1);
		cmp({7'h00, sleep}, 8'h01);
		@(posedge clk) serial_in <= 0;
		cyc(12);
		cmp({7'h00, sleep}, 8'h00);
		wrap_up;
	end
endmodule
`default_nettype wire
